// ==== hw/aotbc_params.svh ====
// constants for the adaptive on-time buck control sequencer
`ifndef AOTBC_PARAMS_SVH
`define AOTBC_PARAMS_SVH
`define AOTBC_CLK_MHZ 125
`define AOTBC_TOFF_MIN_NS 360
`define AOTBC_TON_MIN_NS 60
`define AOTBC_BLANK_NS 150
`define AOTBC_DEAD_NS 30
`define AOTBC_SS_TIME_US 6000
`define AOTBC_STEP_UV 9700
`define AOTBC_VREF_UV 800000
`define AOTBC_FSW_KHZ 200
// least times round up, to whole cycles
`define AOTBC_CYC_UP(ns) ((((ns) * `AOTBC_CLK_MHZ) + 999) / 1000)
`define AOTBC_TOFF_MIN_CYC `AOTBC_CYC_UP(`AOTBC_TOFF_MIN_NS)
`define AOTBC_TON_MIN_CYC `AOTBC_CYC_UP(`AOTBC_TON_MIN_NS)
`define AOTBC_BLANK_CYC `AOTBC_CYC_UP(`AOTBC_BLANK_NS)
`define AOTBC_DEAD_CYC `AOTBC_CYC_UP(`AOTBC_DEAD_NS)
`define AOTBC_SS_STEPS ((`AOTBC_VREF_UV + `AOTBC_STEP_UV - 1) / `AOTBC_STEP_UV)
`define AOTBC_SS_STEP_CYC ((`AOTBC_SS_TIME_US * `AOTBC_CLK_MHZ) / `AOTBC_SS_STEPS)
`endif

// ==== hw/aotbc_pkg.sv ====
// types of the adaptive on-time buck control sequencer
package aotbc_pkg;
  typedef enum logic [5:0] {
    AOTBC_ST_IDLE = 6'h01,
    AOTBC_ST_DEAD_H = 6'h02,
    AOTBC_ST_ON = 6'h04,
    AOTBC_ST_DEAD_L = 6'h08,
    AOTBC_ST_OFF = 6'h10,
    AOTBC_ST_FAULT = 6'h20
  } aotbc_state_t;
endpackage : aotbc_pkg

// ==== hw/aotbc_soft_start.sv ====
// soft-start reference staircase generator
`timescale 1ns/1ns
`include "aotbc_params.svh"
module aotbc_soft_start #(
  parameter int STEP_CYC = `AOTBC_SS_STEP_CYC,
  parameter int STEPS = `AOTBC_SS_STEPS,
  parameter int CODE_W = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic restart_i,
  // reference
  output logic [CODE_W-1:0] ref_code_o,
  output logic done_o
);
  localparam int DIV_W = $clog2(STEP_CYC + 1);
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [CODE_W-1:0] code_r, code_nxt;
  logic done_r, done_nxt;

  always_comb begin
    div_nxt = div_r;
    code_nxt = code_r;
    done_nxt = done_r;
    if (!run_i || restart_i) begin
      div_nxt = '0;
      code_nxt = '0;
      done_nxt = 1'b0;
    end else if (!done_r) begin
      if (div_r == DIV_W'(STEP_CYC - 1)) begin
        div_nxt = '0;
        code_nxt = code_r + CODE_W'(1);
        if (code_r == CODE_W'(STEPS - 1)) begin
          done_nxt = 1'b1;
        end
      end else begin
        div_nxt = div_r + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r <= '0;
      code_r <= '0;
      done_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      code_r <= code_nxt;
      done_r <= done_nxt;
    end
  end

  assign ref_code_o = code_r;
  assign done_o = done_r;

  ramp_holds_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_r && run_i && !restart_i |=> code_r == $past(code_r))
    else $error("reference moved after ramp done");
  ramp_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(done_r) |-> code_r == CODE_W'(STEPS))
    else $error("ramp ended at wrong code");
endmodule : aotbc_soft_start

// ==== hw/aotbc_ctrl.sv ====
// adaptive on-time buck control sequencer
`timescale 1ns/1ns
`include "aotbc_params.svh"
module aotbc_ctrl #(
  parameter int TON_W = 16,
  parameter int CODE_W = 7,
  parameter int SS_STEP_CYC = `AOTBC_SS_STEP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control pins
  input wire logic enable_i,
  // analog comparators, asynchronous
  input wire logic feedback_low_i,
  input wire logic overcurrent_i,
  // on-time estimate in clock cycles, from estimator
  input wire logic [TON_W-1:0] ton_est_i,
  // gate drive
  output logic high_drive_o,
  output logic low_drive_o,
  // reference dac and foldback threshold code
  output logic [CODE_W-1:0] ref_code_o,
  output logic [CODE_W-1:0] overcurrent_threshold_o,
  output logic soft_start_done_o
);
  localparam int TOFF_CYC = `AOTBC_TOFF_MIN_CYC;
  localparam int TON_CYC = `AOTBC_TON_MIN_CYC;
  localparam int BLANK_CYC = `AOTBC_BLANK_CYC;
  localparam int DEAD_CYC = `AOTBC_DEAD_CYC;
  localparam int CNT_W = TON_W;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [1:0] en_s_r, en_s_nxt;
  logic [1:0] fb_s_r, fb_s_nxt;
  logic [1:0] oc_s_r, oc_s_nxt;
  logic en_ok, fb_low, oc_hit;

  always_comb begin
    en_s_nxt = {en_s_r[0], enable_i};
    fb_s_nxt = {fb_s_r[0], feedback_low_i};
    oc_s_nxt = {oc_s_r[0], overcurrent_i};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_s_r <= '0;
      fb_s_r <= '0;
      oc_s_r <= '0;
    end else begin
      en_s_r <= en_s_nxt;
      fb_s_r <= fb_s_nxt;
      oc_s_r <= oc_s_nxt;
    end
  end

  assign en_ok = en_s_r[1];
  assign fb_low = fb_s_r[1];
  assign oc_hit = oc_s_r[1];

  // ------------------------------------------------------------
  // soft-start
  // ------------------------------------------------------------
  logic restart_r, restart_nxt;
  logic [CODE_W-1:0] ss_code;
  logic ss_done;

  aotbc_soft_start #(
    .STEP_CYC(SS_STEP_CYC),
    .STEPS(`AOTBC_SS_STEPS),
    .CODE_W(CODE_W)
  ) u_soft_start (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(en_ok),
    .restart_i(restart_r),
    .ref_code_o(ss_code),
    .done_o(ss_done)
  );

  // ------------------------------------------------------------
  // switching sequencer
  // ------------------------------------------------------------
  aotbc_pkg::aotbc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] ton_len;
  logic hi_r, hi_nxt;
  logic lo_r, lo_nxt;
  logic [CODE_W-1:0] ref_r, ref_nxt;
  logic [CODE_W-1:0] thr_r, thr_nxt;
  logic done_r, done_nxt;

  // floor on estimator value
  assign ton_len = (ton_est_i < CNT_W'(TON_CYC)) ? CNT_W'(TON_CYC) : ton_est_i;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hi_nxt = 1'b0;
    lo_nxt = 1'b0;
    restart_nxt = 1'b0;
    ref_nxt = ss_code;
    done_nxt = ss_done;
    // threshold folds with reference and feedback state
    thr_nxt = fb_low ? (ss_code >> 1) + (ss_code >> 2) : ss_code;
    if (!en_ok) begin
      state_nxt = aotbc_pkg::AOTBC_ST_IDLE;
      cnt_nxt = '0;
    end else begin
      unique case (state_r)
        aotbc_pkg::AOTBC_ST_IDLE: begin
          if (fb_low && ss_code != '0) begin
            state_nxt = aotbc_pkg::AOTBC_ST_DEAD_H;
            cnt_nxt = '0;
          end
        end
        aotbc_pkg::AOTBC_ST_DEAD_H: begin
          if (cnt_r == CNT_W'(DEAD_CYC - 1)) begin
            state_nxt = aotbc_pkg::AOTBC_ST_ON;
            cnt_nxt = '0;
            hi_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
        aotbc_pkg::AOTBC_ST_ON: begin
          if (cnt_r >= ton_len - CNT_W'(1)) begin
            state_nxt = aotbc_pkg::AOTBC_ST_DEAD_L;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
            hi_nxt = 1'b1;
          end
        end
        aotbc_pkg::AOTBC_ST_DEAD_L: begin
          if (cnt_r == CNT_W'(DEAD_CYC - 1)) begin
            state_nxt = aotbc_pkg::AOTBC_ST_OFF;
            cnt_nxt = '0;
            lo_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
        aotbc_pkg::AOTBC_ST_OFF: begin
          if (cnt_r >= CNT_W'(BLANK_CYC) && oc_hit) begin
            state_nxt = aotbc_pkg::AOTBC_ST_FAULT;
            restart_nxt = 1'b1;
            cnt_nxt = '0;
          end else if (cnt_r >= CNT_W'(TOFF_CYC - 1) && fb_low) begin
            state_nxt = aotbc_pkg::AOTBC_ST_DEAD_H;
            cnt_nxt = '0;
          end else begin
            lo_nxt = 1'b1;
            if (cnt_r != {CNT_W{1'b1}}) begin
              cnt_nxt = cnt_r + CNT_W'(1);
            end
          end
        end
        aotbc_pkg::AOTBC_ST_FAULT: begin
          state_nxt = aotbc_pkg::AOTBC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= aotbc_pkg::AOTBC_ST_IDLE;
      cnt_r <= '0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      restart_r <= 1'b0;
      ref_r <= '0;
      thr_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      restart_r <= restart_nxt;
      ref_r <= ref_nxt;
      thr_r <= thr_nxt;
      done_r <= done_nxt;
    end
  end

  assign high_drive_o = hi_r;
  assign low_drive_o = lo_r;
  assign ref_code_o = ref_r;
  assign overcurrent_threshold_o = thr_r;
  assign soft_start_done_o = done_r;

  // ------------------------------------------------------------
  // check helpers: run length of each drive
  // ------------------------------------------------------------
  logic [CNT_W-1:0] on_run_r, on_run_nxt;
  logic [CNT_W-1:0] lo_run_r, lo_run_nxt;

  // counts saturate so a long off-time cannot wrap
  always_comb begin
    on_run_nxt = '0;
    lo_run_nxt = '0;
    if (hi_r) begin
      on_run_nxt = on_run_r;
      if (on_run_r != {CNT_W{1'b1}}) begin
        on_run_nxt = on_run_r + CNT_W'(1);
      end
    end
    if (lo_r) begin
      lo_run_nxt = lo_run_r;
      if (lo_run_r != {CNT_W{1'b1}}) begin
        lo_run_nxt = lo_run_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      on_run_r <= '0;
      lo_run_r <= '0;
    end else begin
      on_run_r <= on_run_nxt;
      lo_run_r <= lo_run_nxt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence hi_fall_s;
    $fell(hi_r);
  endsequence

  sequence lo_fall_s;
    $fell(lo_r);
  endsequence

  sequence hi_end_s;
    $fell(hi_r) ##0 state_r == aotbc_pkg::AOTBC_ST_DEAD_L;
  endsequence

  sequence lo_end_s;
    $fell(lo_r) ##0 state_r == aotbc_pkg::AOTBC_ST_DEAD_H;
  endsequence

  never_overlap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(hi_r && lo_r))
    else $error("both drives on");
  dead_hi_lo_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hi_fall_s |-> !lo_r [*4])
    else $error("dead time after high-side too short");
  dead_lo_hi_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lo_fall_s |-> !hi_r [*4])
    else $error("dead time after low-side too short");
  min_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(hi_r) |-> hi_r [*8] or (##[1:7] !en_ok))
    else $error("on-time below minimum");
  low_after_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hi_fall_s ##0 en_ok |-> ##[4:6] (lo_r || !en_ok))
    else $error("low-side not on after on-time");
  min_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lo_end_s |-> lo_run_r >= CNT_W'(TOFF_CYC))
    else $error("off-time below minimum");
  fb_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == aotbc_pkg::AOTBC_ST_OFF && cnt_r >= CNT_W'(TOFF_CYC - 1) && fb_low && !oc_hit && en_ok
    |-> ##[5:6] (hi_r || !en_ok))
    else $error("on-time not started after trigger");
  blank_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == aotbc_pkg::AOTBC_ST_OFF && cnt_r < CNT_W'(BLANK_CYC) |=> state_r != aotbc_pkg::AOTBC_ST_FAULT)
    else $error("overcurrent seen inside blanking");
  hiccup_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == aotbc_pkg::AOTBC_ST_FAULT |-> !hi_r && !lo_r ##2 ref_r == '0)
    else $error("hiccup did not clear drives and reference");
  disabled_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en_ok [*2] |-> !hi_r && !lo_r)
    else $error("drive on while disabled");

  // ------------------------------------------------------------
  // length, foldback and restart checks
  // ------------------------------------------------------------
  on_floor_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hi_end_s |-> on_run_r >= CNT_W'(TON_CYC))
    else $error("on-time shorter than floor");
  on_length_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hi_end_s ##0 $past(ton_est_i) >= CNT_W'(TON_CYC) ##0 $past(ton_est_i) == $past(ton_est_i, 2)
    |-> on_run_r == $past(ton_est_i))
    else $error("on-time differs from estimate");
  thr_fold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    thr_r <= ref_r)
    else $error("threshold above reference code");
  thr_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fb_low && ss_code != '0 |=> thr_r < ref_r)
    else $error("threshold not folded back");
  fault_short_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == aotbc_pkg::AOTBC_ST_FAULT |=> state_r == aotbc_pkg::AOTBC_ST_IDLE && !hi_r && !lo_r)
    else $error("hiccup did not return to idle");
  ref_restart_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    restart_r |=> ss_code == '0)
    else $error("ramp not restarted from zero");
  on_needs_ref_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(hi_r) |-> ref_r != '0)
    else $error("on-time started with zero reference");
endmodule : aotbc_ctrl

// ==== testbench/aotbc_plant.sv ====
// far-side model: gate drivers, power stage and sense comparators
`timescale 1ns/1ns
module aotbc_plant (
  // clock
  input wire logic clk_i,
  // gate drive
  input wire logic high_drive_i,
  input wire logic low_drive_i,
  // bench stimulus
  input wire logic fb_force_i,
  input wire logic oc_force_i,
  // comparators and watch flag
  output logic feedback_low_o,
  output logic overcurrent_o,
  output logic overlap_o
);
  // conduction on the high side lifts the output above reference
  assign feedback_low_o = fb_force_i & ~high_drive_i;
  // current is sensed only through the low-side switch
  assign overcurrent_o = oc_force_i & low_drive_i;
  logic seen_r = 1'b0;
  // sticky shoot-through flag
  always @(posedge clk_i) begin
    if (high_drive_i && low_drive_i) seen_r <= 1'b1;
  end
  assign overlap_o = seen_r;
endmodule : aotbc_plant

// ==== testbench/tb_top.sv ====
// self-checking bench for the buck control sequencer
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [15:0] ton; int hold; int width;} aotbc_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b1;
  logic fb_force = 1'b0;
  logic oc_force = 1'b0;
  logic [15:0] ton_est = 16'h0014;
  logic fb_low, oc, hd, ld, done, overlap;
  logic [6:0] ref_code, thr;
  int error_cnt = 0;
  int checks = 0;
  int n;
  aotbc_row_t rows [4] = '{'{16'h0014, 100, 20}, '{16'h0008, 0, 8}, '{16'h0003, 100, 8}, '{16'h0032, 0, 50}};

  always #4 clk = ~clk;

  aotbc_ctrl #(.SS_STEP_CYC(4)) aotbc_ctrl_inst (
    .clk_i(clk), .rst_n_i(rst_n), .enable_i(enable), .feedback_low_i(fb_low), .overcurrent_i(oc),
    .ton_est_i(ton_est), .high_drive_o(hd), .low_drive_o(ld), .ref_code_o(ref_code),
    .overcurrent_threshold_o(thr), .soft_start_done_o(done)
  );

  aotbc_plant aotbc_plant_inst (
    .clk_i(clk), .high_drive_i(hd), .low_drive_i(ld), .fb_force_i(fb_force), .oc_force_i(oc_force),
    .feedback_low_o(fb_low), .overcurrent_o(oc), .overlap_o(overlap)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // counts cycles while the chosen drive holds a level
  task automatic span(input bit sel, input logic lvl, output int cnt);
    cnt = 0;
    while ((sel ? ld : hd) === lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > 3000) begin
        error_cnt++;
        $display("Error at %0t: wait limit", $time);
        test_done();
      end
    end
  endtask : span

  task automatic ramp(output int cnt);
    for (cnt = 0; cnt < 1000 && done !== 1'b1; cnt++) @(negedge clk);
    check(done, 1'b1);
    check(ref_code, 7'h53);
    if (done !== 1'b1) test_done();
  endtask : ramp

  initial begin
    repeat (4) @(negedge clk);
    check({hd, ld, done, ref_code}, 16'h0000);
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    ramp(n);
    repeat (50) @(negedge clk);
    check(ref_code, 7'h53);
    for (int i = 0; i < 4; i++) begin
      ton_est = rows[i].ton;
      repeat (rows[i].hold) @(negedge clk);
      if (i > 0) check(ld, 1'b1);
      if (rows[i].hold > 0) check(thr, 7'h53);
      fb_force = 1'b1;
      if (rows[i].hold == 0) begin
        repeat (10) @(negedge clk);
        check(thr < 7'h53, 1'b1);
      end
      span(1, 1'b1, n);
      n = n + rows[i].hold + ((rows[i].hold == 0) ? 10 : 0);
      if (i > 0) check(n >= 45 && (rows[i].hold > 0 || n <= 52), 1'b1);
      span(0, 1'b0, n);
      if (i > 0) check(n, 4);
      fb_force = 1'b0;
      span(0, 1'b1, n);
      check(n, rows[i].width);
      span(1, 1'b0, n);
      check(n, 4);
    end
    // overcurrent inside blanking is ignored, later it trips
    oc_force = 1'b1;
    repeat (10) @(negedge clk);
    oc_force = 1'b0;
    repeat (15) @(negedge clk);
    check(ld, 1'b1);
    oc_force = 1'b1;
    span(1, 1'b1, n);
    check(n <= 8, 1'b1);
    check(hd, 1'b0);
    oc_force = 1'b0;
    repeat (2) @(negedge clk);
    check({done, ref_code}, 16'h0000);
    ramp(n);
    check(n >= 320 && n <= 340, 1'b1);
    // disable in mid on-time
    fb_force = 1'b1;
    span(0, 1'b0, n);
    enable = 1'b0;
    repeat (6) @(negedge clk);
    check({hd, ld, done, ref_code}, 16'h0000);
    check(overlap, 1'b0);
    test_done();
  end
endmodule : tb_top
